// >>> hdl/pmc_pkg.sv
package pmc_pkg;
	// operating modes, one-hot
	typedef enum logic [4:0] {
		MODE_FULL_ON   = 5'h01,
		MODE_ACTIVE    = 5'h02,
		MODE_SLEEP     = 5'h04,
		MODE_DEEP      = 5'h08,
		MODE_HIBERNATE = 5'h10
	} mode_t;

	// register indices on the plain port
	localparam logic [3:0] REG_PLL_CONTROL  = 4'h0;
	localparam logic [3:0] REG_REG_CONTROL  = 4'h1;
	localparam logic [3:0] REG_MODE_REQUEST = 4'h2;
	localparam logic [3:0] REG_PERIPH_GATE  = 4'h3;
	localparam logic [3:0] REG_STATUS       = 4'h4;

	// pll control field positions
	localparam int PLL_OFF_BIT    = 0;
	localparam int PLL_BYPASS_BIT = 1;

	// regulator control layout
	localparam int VR_REGULATOR_FREQUENCY_FIELD_LSB  = 0;
	localparam int VR_LEVEL_LSB = 2;
	localparam int VR_LEVEL_W   = 4;
	localparam int VR_BYPASS_BIT = 6;
	localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_HIBERNATE = 2'h0;
	localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_RESET     = 2'h3;
	localparam logic [3:0] LEVEL_RESET    = 4'h8;
	localparam int LEVEL_STEP_MV = 50;

	// mode request codes
	localparam logic [1:0] REQ_FULL_ON = 2'h0;
	localparam logic [1:0] REQ_ACTIVE  = 2'h1;
	localparam logic [1:0] REQ_SLEEP   = 2'h2;
	localparam logic [1:0] REQ_DEEP    = 2'h3;

	localparam int PERIPH_N = 8;

	// clock and supply controls
	typedef struct packed {
		logic pll_enable;
		logic pll_bypass;
		logic core_clock_en;
		logic sys_clock_en;
		logic supply_on;
	} power_ctl_t;
endpackage : pmc_pkg

// >>> hdl/pmc_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser, change accepted when stages two and three agree
module pmc_sync (
	input  wire logic i_clock, // clock
	input  wire logic i_rst,   // sync reset
	input  wire logic i_ce,    // clock enable
	input  wire logic i_async, // pin level
	output logic      o_level  // filtered level
);
	logic s1;
	logic s2;
	logic s3;

	// shift chain, s1 feeds s2 only
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			o_level <= 1'b0;
		end else if (i_ce) begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				o_level <= s3;
		end
	end
endmodule : pmc_sync

// >>> hdl/pmc_rise.sv
`timescale 1ns/1ps
// one-cycle pulse on a rising level
module pmc_rise (
	input  wire logic i_clock, // clock
	input  wire logic i_rst,   // sync reset
	input  wire logic i_ce,    // clock enable
	input  wire logic i_level, // synchronised level
	output logic      o_pulse  // rise pulse
);
	logic last;

	// remember previous level
	always_ff @(posedge i_clock) begin
		if (i_rst)
			last <= 1'b0;
		else if (i_ce)
			last <= i_level;
	end

	assign o_pulse = i_level & ~last;
endmodule : pmc_rise

// >>> hdl/power_mode_controller.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module power_mode_controller #(
	parameter int PERIPH_N = pmc_pkg::PERIPH_N
) (
	input  wire logic                i_clock,       // 100 MHz clock
	input  wire logic                i_rst,         // sync reset, high
	input  wire logic                i_ce,          // clock enable
	input  wire logic [3:0]          i_addr,        // register index
	input  wire logic [31:0]         i_wdata,       // write data
	input  wire logic                i_wr,          // write strobe
	input  wire logic                i_rd,          // read strobe
	input  wire logic                i_rtc_wake,    // rtc interrupt pin
	input  wire logic                i_reset_wake,  // reset pin request
	input  wire logic                i_wake_event,  // other wake events
	output logic [31:0]              o_rdata,       // read data
	output pmc_pkg::power_ctl_t      o_power,       // clock/supply ctl
	output logic [3:0]               o_vr_level,    // supply level code
	output logic                     o_vr_bypass,   // regulator bypassed
	output logic                     o_dma_l1_ok,   // dma to l1 allowed
	output logic                     o_pins_float,  // pins high-z
	output logic                     o_boot_start,  // boot pulse
	output logic [PERIPH_N-1:0]      o_periph_clk_en // peripheral gates
);
	pmc_pkg::mode_t      mode;
	pmc_pkg::mode_t      next_mode;
	logic                pll_off;
	logic                pll_bypass;
	logic [1:0]          vr_regulator_frequency_field;
	logic [3:0]          vr_level;
	logic                vr_bypass;
	logic [PERIPH_N-1:0] periph_gate;
	logic                req_valid;
	logic [1:0]          req_code;
	logic                rtc_level;
	logic                rst_level;
	logic                rtc_pulse;
	logic                rst_pulse;
	logic                hib_write;
	logic                boot_req;

	// pin synchronisers
	pmc_sync u_sync_rtc (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_async (i_rtc_wake),
		.o_level (rtc_level)
	);
	pmc_sync u_sync_rst (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_async (i_reset_wake),
		.o_level (rst_level)
	);
	pmc_rise u_rise_rtc (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_level (rtc_level),
		.o_pulse (rtc_pulse)
	);
	pmc_rise u_rise_rst (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_level (rst_level),
		.o_pulse (rst_pulse)
	);

	// write decode to hibernate
	assign hib_write = i_wr && (i_addr == pmc_pkg::REG_REG_CONTROL) &&
		(i_wdata[pmc_pkg::VR_REGULATOR_FREQUENCY_FIELD_LSB +: 2] ==
		 pmc_pkg::REGULATOR_FREQUENCY_FIELD_HIBERNATE);

	// pll control register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pll_off    <= 1'b0;
			pll_bypass <= 1'b0;
		end else if (i_ce) begin
			if (i_wr && i_addr == pmc_pkg::REG_PLL_CONTROL) begin
				// pll may only be switched off in active mode
				if (mode == pmc_pkg::MODE_ACTIVE)
					pll_off <= i_wdata[pmc_pkg::PLL_OFF_BIT];
				else
					pll_off <= 1'b0;
				pll_bypass <= i_wdata[pmc_pkg::PLL_BYPASS_BIT];
			end
			// a wake into full-on must not leave the pll marked off
			if (next_mode == pmc_pkg::MODE_FULL_ON)
				pll_off <= 1'b0;
		end
	end

	// regulator control register
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			vr_regulator_frequency_field   <= pmc_pkg::REGULATOR_FREQUENCY_FIELD_RESET;
			vr_level  <= pmc_pkg::LEVEL_RESET;
			vr_bypass <= 1'b0;
		end else if (i_ce) begin
			// a wake from hibernate undoes the 00 that caused it
			if (boot_req) begin
				vr_regulator_frequency_field <= pmc_pkg::REGULATOR_FREQUENCY_FIELD_RESET;
			end else if (i_wr &&
				i_addr == pmc_pkg::REG_REG_CONTROL) begin
				vr_regulator_frequency_field   <= i_wdata[pmc_pkg::VR_REGULATOR_FREQUENCY_FIELD_LSB +: 2];
				vr_level  <= i_wdata[pmc_pkg::VR_LEVEL_LSB +:
					pmc_pkg::VR_LEVEL_W];
				vr_bypass <= i_wdata[pmc_pkg::VR_BYPASS_BIT];
			end
		end
	end

	// peripheral clock gates
	always_ff @(posedge i_clock) begin
		if (i_rst)
			periph_gate <= {PERIPH_N{1'b1}};
		else if (i_ce && i_wr && i_addr == pmc_pkg::REG_PERIPH_GATE)
			periph_gate <= i_wdata[PERIPH_N-1:0];
	end

	// mode request latch, consumed by the sequencer
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			req_valid <= 1'b0;
			req_code  <= pmc_pkg::REQ_FULL_ON;
		end else if (i_ce) begin
			if (i_wr && i_addr == pmc_pkg::REG_MODE_REQUEST) begin
				req_valid <= 1'b1;
				req_code  <= i_wdata[1:0];
			end else begin
				// a request is acted on in the next cycle only
				req_valid <= 1'b0;
			end
		end
	end

	// wake out of hibernate starts a boot
	assign boot_req = (mode == pmc_pkg::MODE_HIBERNATE) &&
		(rtc_pulse || rst_pulse);

	// next mode selection
	always_comb begin
		next_mode = mode;
		case (mode)
		pmc_pkg::MODE_FULL_ON, pmc_pkg::MODE_ACTIVE: begin
			// software requests are only heard while the core runs
			if (hib_write) begin
				next_mode = pmc_pkg::MODE_HIBERNATE;
			end else if (req_valid) begin
				case (req_code)
				pmc_pkg::REQ_FULL_ON: begin
					if (!pll_off)
						next_mode = pmc_pkg::MODE_FULL_ON;
				end
				pmc_pkg::REQ_ACTIVE: begin
					next_mode = pmc_pkg::MODE_ACTIVE;
				end
				pmc_pkg::REQ_SLEEP: begin
					if (!pll_off)
						next_mode = pmc_pkg::MODE_SLEEP;
				end
				pmc_pkg::REQ_DEEP: begin
					next_mode = pmc_pkg::MODE_DEEP;
				end
				default: begin
					next_mode = mode;
				end
				endcase
			end
		end
		pmc_pkg::MODE_SLEEP: begin
			// any wake source ends sleep
			if (i_wake_event || rtc_pulse || rst_pulse) begin
				if (pll_bypass)
					next_mode = pmc_pkg::MODE_ACTIVE;
				else
					next_mode = pmc_pkg::MODE_FULL_ON;
			end
		end
		pmc_pkg::MODE_DEEP: begin
			// other wake events ignored here
			if (rst_pulse)
				next_mode = pmc_pkg::MODE_FULL_ON;
			else if (rtc_pulse)
				next_mode = pmc_pkg::MODE_ACTIVE;
		end
		pmc_pkg::MODE_HIBERNATE: begin
			// only the rtc or the reset pin restore the supply
			if (boot_req)
				next_mode = pmc_pkg::MODE_FULL_ON;
		end
		default: begin
			next_mode = pmc_pkg::MODE_FULL_ON;
		end
		endcase
	end

	// mode register
	always_ff @(posedge i_clock) begin
		if (i_rst)
			mode <= pmc_pkg::MODE_FULL_ON;
		else if (i_ce)
			mode <= next_mode;
	end

	// clock, pll and supply outputs from next mode
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_power.pll_enable    <= 1'b1;
			o_power.pll_bypass    <= 1'b0;
			o_power.core_clock_en <= 1'b1;
			o_power.sys_clock_en  <= 1'b1;
			o_power.supply_on     <= 1'b1;
		end else if (i_ce) begin
			// all off but the supply unless a mode says otherwise
			o_power.pll_enable    <= 1'b0;
			o_power.pll_bypass    <= 1'b0;
			o_power.core_clock_en <= 1'b0;
			o_power.sys_clock_en  <= 1'b0;
			o_power.supply_on     <= 1'b1;
			case (next_mode)
			pmc_pkg::MODE_FULL_ON: begin
				// pll locked and in the path, both clocks run
				o_power.pll_enable    <= 1'b1;
				o_power.core_clock_en <= 1'b1;
				o_power.sys_clock_en  <= 1'b1;
			end
			pmc_pkg::MODE_ACTIVE: begin
				// input clock straight through, pll may be off
				o_power.pll_enable    <= ~pll_off;
				o_power.pll_bypass    <= 1'b1;
				o_power.core_clock_en <= 1'b1;
				o_power.sys_clock_en  <= 1'b1;
			end
			pmc_pkg::MODE_SLEEP: begin
				// core halted, system clock keeps peripherals alive
				o_power.pll_enable   <= 1'b1;
				o_power.pll_bypass   <= pll_bypass;
				o_power.sys_clock_en <= 1'b1;
			end
			pmc_pkg::MODE_DEEP: begin
				// only the asynchronous blocks keep running
				o_power.pll_enable <= 1'b0;
			end
			pmc_pkg::MODE_HIBERNATE: begin
				// supply off, every clock and the pll stopped
				o_power.supply_on <= 1'b0;
			end
			default: begin
				o_power.supply_on <= 1'b1;
			end
			endcase
		end
	end

	// dma to level-one memory only while active
	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_dma_l1_ok <= 1'b0;
		else if (i_ce)
			// sleep and every other mode refuse it
			o_dma_l1_ok <= (next_mode ==
				pmc_pkg::MODE_ACTIVE);
	end

	// pins float while the core supply is off
	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_pins_float <= 1'b0;
		else if (i_ce)
			o_pins_float <= (next_mode ==
				pmc_pkg::MODE_HIBERNATE);
	end

	// regulator level, bypass and peripheral gate outputs
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_vr_level      <= pmc_pkg::LEVEL_RESET;
			o_vr_bypass     <= 1'b0;
			o_periph_clk_en <= {PERIPH_N{1'b1}};
		end else if (i_ce) begin
			o_vr_level      <= vr_level;
			o_vr_bypass     <= vr_bypass;
			o_periph_clk_en <= periph_gate;
		end
	end

	// one-cycle boot pulse on the way out of hibernate
	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_boot_start <= 1'b0;
		else if (i_ce)
			o_boot_start <= boot_req;
	end

	// register read port, data one cycle after strobe
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else if (i_ce) begin
			// idle cycles read back as zero
			o_rdata <= 32'h0;
			if (i_rd) begin
				case (i_addr)
				pmc_pkg::REG_PLL_CONTROL:
					o_rdata <= {30'h0, pll_bypass, pll_off};
				pmc_pkg::REG_REG_CONTROL:
					o_rdata <= {25'h0, vr_bypass, vr_level, vr_regulator_frequency_field};
				pmc_pkg::REG_PERIPH_GATE:
					o_rdata <= 32'(periph_gate);
				pmc_pkg::REG_STATUS:
					o_rdata <= {27'h0, mode};
				default:
					o_rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule : power_mode_controller

// >>> verif/power_mode_controller_assertions.sv
`timescale 1ns/1ps
// ties each power output to the mode it belongs to
module power_mode_controller_assertions (
	input wire logic                i_clock,      // clock
	input wire logic                i_rst,        // sync reset
	input wire logic                i_ce,         // clock enable
	input wire logic [3:0]          i_addr,       // register index
	input wire logic [31:0]         i_wdata,      // write data
	input wire logic                i_wr,         // write strobe
	input wire logic                i_rd,         // read strobe
	input wire logic [31:0]         o_rdata,      // read data
	input wire pmc_pkg::power_ctl_t o_power,      // clock/supply ctl
	input wire logic                o_dma_l1_ok,  // dma allowed
	input wire logic                o_pins_float, // pins high-z
	input wire logic                o_boot_start  // boot pulse
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	// reset, full-on and active clocking
	a_reset_full_on: assert property (disable iff (1'b0) i_rst |=>
		o_power == 5'h17 && !o_dma_l1_ok && !o_pins_float)
		else $error("reset did not give full-on");
	a_full_on_pll: assert property (o_power.supply_on &&
		!o_power.pll_bypass && o_power.core_clock_en |->
		o_power.pll_enable && o_power.sys_clock_en)
		else $error("unbypassed core clock without pll");
	a_dma_in_active: assert property (o_dma_l1_ok |->
		o_power.pll_bypass && o_power.core_clock_en && o_power.sys_clock_en)
		else $error("dma allowed outside active mode");
	// sleep, deep sleep and hibernate
	a_sleep_no_dma: assert property (!o_power.core_clock_en &&
		o_power.sys_clock_en |-> o_power.pll_enable && !o_dma_l1_ok)
		else $error("sleep clocking wrong");
	a_deep_clocks: assert property (!o_power.sys_clock_en |->
		!o_power.core_clock_en && !o_power.pll_enable)
		else $error("system clock stopped alone");
	a_hib_float: assert property (o_pins_float == !o_power.supply_on)
		else $error("pin float differs from supply");
	a_hib_clocks: assert property (!o_power.supply_on |->
		o_power == 5'h00) else $error("clocks run without supply");
	a_hib_entry: assert property (i_wr && i_ce &&
		i_addr == pmc_pkg::REG_REG_CONTROL && i_wdata[1:0] == 2'h0 &&
		o_power == 5'h17 ##1 i_ce |=> !o_power.supply_on && o_pins_float)
		else $error("hibernate not entered");
	// boot pulse and read port
	a_boot_pulse: assert property (o_boot_start |=> !o_boot_start)
		else $error("boot pulse longer than one cycle");
	a_boot_full_on: assert property (o_boot_start |->
		##[0:2] o_power == 5'h17) else $error("boot without full-on");
	a_rdata_idle: assert property ($past(i_ce) && !$past(i_rd) |->
		o_rdata == 32'h0) else $error("read data outside its cycle");
	a_read_status: assert property (i_rd && i_ce &&
		i_addr == pmc_pkg::REG_STATUS |=> o_rdata[31:5] == 27'h0 &&
		$onehot(o_rdata[4:0])) else $error("status not one mode");
endmodule : power_mode_controller_assertions

bind power_mode_controller power_mode_controller_assertions assertions_inst (
	.i_clock, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.o_power, .o_dma_l1_ok, .o_pins_float, .o_boot_start);

// >>> verif/pmc_wake_model.sv
`timescale 1ns/1ps
// rtc and reset-pin source, pins move off the clock edge
module pmc_wake_model (
	input  wire logic i_clock,     // clock
	input  wire logic i_rtc_go,    // fire rtc interrupt
	input  wire logic i_pin_go,    // fire reset pin
	output logic      o_rtc_wake,  // rtc interrupt pin
	output logic      o_reset_wake // reset pin request
);
	logic [2:0] rtc_left = 3'h0; // cycles rtc pin stays high
	logic [2:0] pin_left = 3'h0; // cycles reset pin stays high
	// hold each pin long enough to cross the synchroniser
	always @(posedge i_clock) begin
		rtc_left <= i_rtc_go ? 3'h6 : rtc_left - {2'h0, rtc_left != 3'h0};
		pin_left <= i_pin_go ? 3'h6 : pin_left - {2'h0, pin_left != 3'h0};
	end
	// asynchronous sources, 3 ns after the edge
	assign #3 o_rtc_wake   = rtc_left != 3'h0;
	assign #3 o_reset_wake = pin_left != 3'h0;
endmodule : pmc_wake_model

// >>> verif/power_mode_controller_tb.sv
`timescale 1ns/1ps
// mode sequencing driven through the register port
module power_mode_controller_tb;
	logic                i_clock = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
	logic [3:0]          i_addr = 4'h0;
	logic [31:0]         i_wdata = 32'h0, o_rdata, d;
	logic                i_wr = 1'b0, i_rd = 1'b0, i_wake_event = 1'b0;
	logic                rtc_go = 1'b0, pin_go = 1'b0;
	logic                i_rtc_wake, i_reset_wake, o_vr_bypass;
	logic                o_dma_l1_ok, o_pins_float, o_boot_start;
	logic [3:0]          o_vr_level;
	logic [7:0]          o_periph_clk_en;
	pmc_pkg::power_ctl_t o_power;
	int                  err_count = 0, total_checks = 0, boots = 0, cyc = 0;

	power_mode_controller power_mode_controller_inst (.i_clock, .i_rst,
		.i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_rtc_wake, .i_reset_wake,
		.i_wake_event, .o_rdata, .o_power, .o_vr_level, .o_vr_bypass,
		.o_dma_l1_ok, .o_pins_float, .o_boot_start, .o_periph_clk_en);
	pmc_wake_model pmc_wake_model_inst (.i_clock, .i_rtc_go(rtc_go),
		.i_pin_go(pin_go), .o_rtc_wake(i_rtc_wake),
		.o_reset_wake(i_reset_wake));

	// clock, boot pulse count and hang limit
	initial forever #5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		boots <= boots + int'(o_boot_start === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			close_out();
		end
	end

	task automatic close_out;
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge i_clock);
		#1;
	endtask : settle
	task automatic mode_is(input logic [4:0] m);
		logic [31:0] v;
		for (int n = 0; n < 20; n++) begin
			rd(pmc_pkg::REG_STATUS, v);
			if (v === {27'h0, m}) break;
		end
		check(v, {27'h0, m});
	endtask : mode_is
	task automatic req(input logic [1:0] r);
		wr(pmc_pkg::REG_MODE_REQUEST, {30'h0, r});
		settle();
	endtask : req
	task automatic pulse(input int which);
		@(posedge i_clock);
		i_wake_event <= which == 0;
		rtc_go <= which == 1;
		pin_go <= which == 2;
		@(posedge i_clock);
		{i_wake_event, rtc_go, pin_go} <= 3'h0;
		repeat (6) @(posedge i_clock);
	endtask : pulse

	// main sequence
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		#1 check(o_power, 5'h17);
		check(o_vr_level, pmc_pkg::LEVEL_RESET);
		check(o_periph_clk_en, 8'hff);
		mode_is(pmc_pkg::MODE_FULL_ON);
		rd(4'hf, d);
		check(d, 32'h0);
		wr(pmc_pkg::REG_PERIPH_GATE, 32'h5a);
		settle();
		check(o_periph_clk_en, 8'h5a);
		wr(pmc_pkg::REG_PLL_CONTROL, 32'h1);
		rd(pmc_pkg::REG_PLL_CONTROL, d);
		check(d, 32'h0);
		req(pmc_pkg::REQ_DEEP);
		check(o_power, 5'h01);
		pulse(0);
		mode_is(pmc_pkg::MODE_DEEP);
		pulse(1);
		mode_is(pmc_pkg::MODE_ACTIVE);
		check({o_power, o_dma_l1_ok}, 6'h3f);
		wr(pmc_pkg::REG_PLL_CONTROL, 32'h3);
		wr(pmc_pkg::REG_MODE_REQUEST, {30'h0, pmc_pkg::REQ_FULL_ON});
		req(pmc_pkg::REQ_SLEEP);
		mode_is(pmc_pkg::MODE_ACTIVE);
		check(o_power.pll_enable, 1'b0);
		rd(pmc_pkg::REG_PLL_CONTROL, d);
		check(d, 32'h3);
		req(pmc_pkg::REQ_DEEP);
		pulse(2);
		mode_is(pmc_pkg::MODE_FULL_ON);
		rd(pmc_pkg::REG_PLL_CONTROL, d);
		check(d, 32'h2);
		wr(pmc_pkg::REG_PLL_CONTROL, 32'h2);
		req(pmc_pkg::REQ_SLEEP);
		mode_is(pmc_pkg::MODE_SLEEP);
		check({o_power.pll_enable, o_power[2:0], o_dma_l1_ok}, 5'h16);
		pulse(0);
		mode_is(pmc_pkg::MODE_ACTIVE);
		wr(pmc_pkg::REG_PLL_CONTROL, 32'h0);
		req(pmc_pkg::REQ_FULL_ON);
		req(pmc_pkg::REQ_SLEEP);
		mode_is(pmc_pkg::MODE_SLEEP);
		pulse(0);
		mode_is(pmc_pkg::MODE_FULL_ON);
		req(pmc_pkg::REQ_DEEP);
		mode_is(pmc_pkg::MODE_DEEP);
		pulse(2);
		mode_is(pmc_pkg::MODE_FULL_ON);
		wr(pmc_pkg::REG_REG_CONTROL, 32'h57);
		settle();
		check({o_vr_bypass, o_vr_level}, 5'h15);
		rd(pmc_pkg::REG_REG_CONTROL, d);
		check(d, 32'h57);
		wr(pmc_pkg::REG_REG_CONTROL, 32'h54);
		settle();
		check({o_power, o_pins_float}, 6'h01);
		mode_is(pmc_pkg::MODE_HIBERNATE);
		pulse(1);
		mode_is(pmc_pkg::MODE_FULL_ON);
		check(boots, 1);
		rd(pmc_pkg::REG_REG_CONTROL, d);
		check(d[1:0], pmc_pkg::REGULATOR_FREQUENCY_FIELD_RESET);
		wr(pmc_pkg::REG_REG_CONTROL, 32'h54);
		settle();
		pulse(2);
		mode_is(pmc_pkg::MODE_FULL_ON);
		check(boots, 2);
		req(pmc_pkg::REQ_ACTIVE);
		mode_is(pmc_pkg::MODE_ACTIVE);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		mode_is(pmc_pkg::MODE_FULL_ON);
		check(o_periph_clk_en, 8'hff);
		// a write while the clock enable is low leaves no trace
		@(posedge i_clock);
		i_ce <= 1'b0;
		wr(pmc_pkg::REG_MODE_REQUEST, {30'h0, pmc_pkg::REQ_DEEP});
		i_ce <= 1'b1;
		settle();
		check(o_power, 5'h17);
		close_out();
	end
endmodule : power_mode_controller_tb
